// *** dprr_defs.svh ***
// Constants for the debug power and reset request block.
// Assumes inclusion by package and modules of this block only.
`ifndef DPRR_DEFS_SVH
`define DPRR_DEFS_SVH
`define DPRR_N_DOMAINS      4
`define DPRR_N_SYSDOM       2
`define DPRR_N_ENTRIES      4
`define DPRR_OFS_CTRL       12'h000
`define DPRR_OFS_STATUS     12'h004
`define DPRR_OFS_ENTRY0     12'h010
`define DPRR_PRESENT_VALID  2'h3
`define DPRR_RST_PULSE_CYC  4'h4
`define DPRR_GATE_NONINV    3'h0
`define DPRR_GATE_NSINV     3'h1
`define DPRR_GATE_ROOTINV   3'h2
`define DPRR_GATE_SECINV    3'h3
`define DPRR_GATE_NONE      3'h4
`define DPRR_SYS_ROUTE      4'h3
`endif

// *** dprr_pkg.sv ***
// Types shared by the debug power and reset request ends.
// Assumes dprr_defs.svh is on the include path.
package dprr_pkg;
  `include "dprr_defs.svh"
  typedef enum logic [1:0] {DPRR_RST_IDLE, DPRR_RST_HELD, DPRR_RST_ACKED} dprr_rst_e;
  // Directory entry: presence, power id valid, power domain number
  typedef struct packed {
    logic [1:0] presence;
    logic       power_id_valid_flag;
    logic [3:0] power_domain_number;
  } dprr_entry_s;
endpackage

// *** dprr_if.sv ***
// Link between the debugger-side controller and the power/reset device end.
// Assumes one clock shared by both ends.
interface dprr_if;
  import dprr_pkg::*;
  logic [`DPRR_N_DOMAINS-1:0] domain_power_control;
  logic [`DPRR_N_SYSDOM-1:0]  system_power_control;
  logic                       debug_reset_request_bit;
  logic                       debug_reset_ack_bit;
  dprr_entry_s                directory_entry [`DPRR_N_ENTRIES];
  modport dev (input domain_power_control, system_power_control, debug_reset_request_bit,
               output debug_reset_ack_bit, directory_entry);
  modport ctl (output domain_power_control, system_power_control, debug_reset_request_bit,
               input debug_reset_ack_bit, directory_entry);
endinterface

// *** dprr_rst_seq.sv ***
// Debug reset sequencer for held or pulse option.
// Assumes request is already authentication gated and on clk.
module dprr_rst_seq
  import dprr_pkg::*;
#(
  parameter bit HELD = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Request and results
  input  wire logic req,
  output logic      ack,
  output logic      dbg_in_reset
);
  typedef struct packed {
    dprr_rst_e  st;
    logic       req_d;
    logic [3:0] cnt;
    logic       ack;
    logic       in_rst;
  } dprr_seq_s;
  dprr_seq_s s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.req_d = req;
    case (s_reg.st)
      DPRR_RST_IDLE: begin
        s_next.ack = 1'b0;
        s_next.in_rst = 1'b0;
        if (req && !s_reg.req_d) begin
          s_next.st = DPRR_RST_HELD;
          s_next.in_rst = 1'b1;
          s_next.cnt = `DPRR_RST_PULSE_CYC;
          if (HELD) s_next.ack = 1'b1;
        end
      end
      DPRR_RST_HELD: begin
        if (HELD) begin
          if (!req) begin
            s_next.in_rst = 1'b0;
            s_next.st = DPRR_RST_ACKED;
          end else begin
            s_next.in_rst = 1'b1;
          end
        end else if (s_reg.cnt == 4'h1) begin
          s_next.in_rst = 1'b0;
          s_next.ack = 1'b1;
          s_next.st = DPRR_RST_ACKED;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      DPRR_RST_ACKED: begin
        if (HELD) begin
          s_next.ack = 1'b0;
          s_next.st = DPRR_RST_IDLE;
        end else if (!req) begin
          s_next.ack = 1'b0;
          s_next.st = DPRR_RST_IDLE;
        end
      end
      default: s_next.st = DPRR_RST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign ack = s_reg.ack;
  assign dbg_in_reset = s_reg.in_rst;
endmodule // dprr_rst_seq

// *** dprr_device.sv ***
// Device end: gates power and reset requests, drives power and debug reset.
// Assumes link inputs come from the controller on the same clk.
module dprr_device
  import dprr_pkg::*;
#(
  parameter logic [2:0] DOM_GATE = `DPRR_GATE_NONINV,
  parameter logic [2:0] SYS_GATE = `DPRR_GATE_NONINV,
  parameter bit         HELD     = 1'b1,
  parameter bit         ROOT_EXT = 1'b0,
  parameter bit         SEC_SPLIT = 1'b1
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Link
  dprr_if.dev                            lnk,
  // Authentication
  input  wire logic                      dbg_en,
  input  wire logic                      inv_en,
  input  wire logic                      root_inv_en,
  input  wire logic                      sec_inv_en,
  // Directory contents
  input  wire dprr_entry_s               entry_cfg [`DPRR_N_ENTRIES],
  input  wire logic [`DPRR_N_DOMAINS-1:0] domain_present,
  // Power controller and reset generator
  output logic [`DPRR_N_DOMAINS-1:0]     domain_pwr_req,
  output logic [3:0]                     sys_dom_pwr_req,
  output logic                           dbg_logic_rst
);
  function automatic logic gate_ok(input logic [2:0] g);
    case (g)
      `DPRR_GATE_NONINV:  gate_ok = dbg_en;
      `DPRR_GATE_NSINV:   gate_ok = inv_en;
      `DPRR_GATE_ROOTINV: gate_ok = root_inv_en;
      `DPRR_GATE_SECINV:  gate_ok = sec_inv_en;
      default:            gate_ok = 1'b1;
    endcase
  endfunction

  typedef struct packed {
    logic [`DPRR_N_DOMAINS-1:0] dom;
    logic [3:0]                 sys;
  } dprr_dev_s;
  dprr_dev_s s_reg, s_next;
  logic rst_ok, ack, in_rst;

  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < `DPRR_N_DOMAINS; i++)
      s_next.dom[i] = lnk.domain_power_control[i] & domain_present[i] & gate_ok(DOM_GATE);
    s_next.sys = (|lnk.system_power_control && gate_ok(SYS_GATE)) ? `DPRR_SYS_ROUTE : 4'h0;
    if (ROOT_EXT) rst_ok = root_inv_en;
    else if (SEC_SPLIT) rst_ok = sec_inv_en;
    else rst_ok = inv_en;
  end

  dprr_rst_seq #(.HELD(HELD)) u_seq (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .req          (lnk.debug_reset_request_bit & rst_ok),
    .ack          (ack),
    .dbg_in_reset (in_rst)
  );

  assign lnk.debug_reset_ack_bit = ack;
  generate
    for (genvar e = 0; e < `DPRR_N_ENTRIES; e++) begin : g_ent
      assign lnk.directory_entry[e] = entry_cfg[e];
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign domain_pwr_req = s_reg.dom;
  assign sys_dom_pwr_req = s_reg.sys;
  // Straight from the sequencer flop so release precedes the ack clear
  assign dbg_logic_rst = in_rst;
endmodule // dprr_device

// *** dprr_ctrl.sv ***
// Controller end: AXI4-Lite registers for software, drives the link.
// Assumes one clock; software polls status.
module dprr_ctrl
  import dprr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link
  dprr_if.ctl              lnk
);
  typedef struct packed {
    logic                       aw_ok;
    logic [11:0]                awaddr;
    logic                       w_ok;
    logic [31:0]                wdata;
    logic [3:0]                 wlanes;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [`DPRR_N_ENTRIES-1:0] use_en;
    logic [`DPRR_N_ENTRIES-1:0] saved;
    logic [`DPRR_N_DOMAINS-1:0] dom;
    logic [`DPRR_N_SYSDOM-1:0]  sys;
    logic                       rrq;
  } dprr_ctl_s;
  dprr_ctl_s s_reg, s_next;

  logic [`DPRR_N_ENTRIES-1:0] ent_valid;
  logic [`DPRR_N_DOMAINS-1:0] dom_want;
  logic [31:0]                status_word;
  logic [11:0]                ra;
  logic [3:0]                 eidx;

  generate
    for (genvar e = 0; e < `DPRR_N_ENTRIES; e++) begin : g_ent
      assign ent_valid[e] = (lnk.directory_entry[e].presence == `DPRR_PRESENT_VALID)
                            && lnk.directory_entry[e].power_id_valid_flag;
    end
  endgenerate

  always_comb begin
    dom_want = '0;
    for (int e = 0; e < `DPRR_N_ENTRIES; e++)
      if (ent_valid[e] && s_reg.use_en[e] && !s_reg.saved[e])
        dom_want[lnk.directory_entry[e].power_domain_number[1:0]] = 1'b1;
  end

  assign status_word = {24'h0, 4'(ent_valid), 2'h0, lnk.debug_reset_ack_bit, s_reg.rrq};

  always_comb begin
    s_next = s_reg;
    ra = s_axi_araddr;
    eidx = 4'(ra[5:2] - 4'h4);
    s_next.dom = dom_want;
    if (s_axi_awvalid && !s_reg.aw_ok) begin
      s_next.aw_ok = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_ok) begin
      s_next.w_ok = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wlanes = s_axi_wstrb;
    end
    if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = 2'h0;
      if (s_reg.awaddr == `DPRR_OFS_CTRL) begin
        if (s_reg.wlanes[0]) begin
          s_next.use_en = s_reg.wdata[3:0];
          s_next.saved = s_reg.wdata[7:4] & s_reg.wdata[3:0];
        end
        if (s_reg.wlanes[1]) s_next.sys = s_reg.wdata[9:8];
        if (s_reg.wlanes[2]) s_next.rrq = s_reg.wdata[16];
      end else if (s_reg.awaddr != `DPRR_OFS_STATUS) begin
        s_next.bresp = 2'h2;
      end
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = 2'h0;
      s_next.rdata = 32'h0;
      if (ra == `DPRR_OFS_CTRL)
        s_next.rdata = {15'h0, s_reg.rrq, 6'h0, s_reg.sys, s_reg.saved, s_reg.use_en};
      else if (ra == `DPRR_OFS_STATUS)
        s_next.rdata = status_word;
      else if (ra[11:4] == 8'h01)
        s_next.rdata = {25'h0, lnk.directory_entry[eidx[1:0]]};
      else
        s_next.rresp = 2'h2;
    end
    if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign s_axi_awready = !s_reg.aw_ok;
  assign s_axi_wready = !s_reg.w_ok;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign lnk.domain_power_control = s_reg.dom;
  assign lnk.system_power_control = s_reg.sys;
  assign lnk.debug_reset_request_bit = s_reg.rrq;
endmodule // dprr_ctrl

// *** dprr_monitor.sv ***
// Checker of the link and device outputs of the debug power and reset pair.
// Assumes device defaults: held option, secure split, non-invasive gates; domain presence comes in on domain_present.
`include "dprr_defs.svh"
module dprr_monitor
  import dprr_pkg::*;
(
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  // Link
  input wire logic [`DPRR_N_DOMAINS-1:0] domain_power_control,
  input wire logic [`DPRR_N_SYSDOM-1:0]  system_power_control,
  input wire logic                        debug_reset_request_bit,
  input wire logic                        debug_reset_ack_bit,
  // Device side
  input wire logic                        dbg_en,
  input wire logic                        sec_inv_en,
  input wire logic [`DPRR_N_DOMAINS-1:0] domain_present,
  input wire logic [`DPRR_N_DOMAINS-1:0] domain_pwr_req,
  input wire logic [3:0]                  sys_dom_pwr_req,
  input wire logic                        dbg_logic_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rq_g;
  assign rq_g = debug_reset_request_bit & sec_inv_en;
  sequence start_s;
    debug_reset_ack_bit && dbg_logic_rst;
  endsequence
  sequence release_s;
    !dbg_logic_rst && debug_reset_ack_bit ##1 !debug_reset_ack_bit;
  endsequence
  dom_gate_a: assert property (
    domain_pwr_req == $past(domain_power_control & domain_present & {4{dbg_en}}))
    else $error("domain req wrong");
  sys_route_a: assert property (
    sys_dom_pwr_req == ($past(|system_power_control && dbg_en) ? `DPRR_SYS_ROUTE : 4'h0))
    else $error("system req wrong");
  ack_start_a: assert property ($rose(rq_g) |=> start_s) else $error("no reset start");
  ack_rst_a: assert property ($rose(debug_reset_ack_bit) |-> dbg_logic_rst)
    else $error("ack without reset");
  held_rst_a: assert property (rq_g && debug_reset_ack_bit |-> dbg_logic_rst)
    else $error("reset not held");
  release_order_a: assert property (
    $fell(rq_g) && debug_reset_ack_bit |=> release_s) else $error("release order wrong");
  gate_ignore_a: assert property (!rq_g && !dbg_logic_rst |=> !dbg_logic_rst)
    else $error("reset without request");
  rst_cause_a: assert property (dbg_logic_rst |-> rq_g || $past(rq_g))
    else $error("reset outlives request");
endmodule // dprr_monitor

// *** tb_debug_power_reset_request.sv ***
// Testbench joining controller and device over the link, driven over AXI4-Lite.
// Assumes device defaults and a 250 MHz clock.
`include "dprr_defs.svh"
module tb_debug_power_reset_request
  import dprr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, dbg_en, inv_en, root_inv_en, sec_inv_en, dbg_rst;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, present, dom_pwr, sys_pwr;
  logic [1:0]  bresp, rresp;
  dprr_entry_s cfg [`DPRR_N_ENTRIES];
  int          errors, compares;
  dprr_if lnk ();
  dprr_ctrl i_dprr_ctrl (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lnk(lnk));
  dprr_device i_dprr_device (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .dbg_en(dbg_en),
    .inv_en(inv_en), .root_inv_en(root_inv_en), .sec_inv_en(sec_inv_en), .entry_cfg(cfg),
    .domain_present(present), .domain_pwr_req(dom_pwr), .sys_dom_pwr_req(sys_pwr),
    .dbg_logic_rst(dbg_rst));
  dprr_monitor i_dprr_monitor (.clk(clk), .sys_rst(sys_rst),
    .domain_power_control(lnk.domain_power_control),
    .system_power_control(lnk.system_power_control),
    .debug_reset_request_bit(lnk.debug_reset_request_bit),
    .debug_reset_ack_bit(lnk.debug_reset_ack_bit), .dbg_en(dbg_en), .sec_inv_en(sec_inv_en),
    .domain_present(present),
    .domain_pwr_req(dom_pwr), .sys_dom_pwr_req(sys_pwr), .dbg_logic_rst(dbg_rst));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      aw_ok = aw_ok | (awready === 1'b1);
      w_ok = w_ok | (wready === 1'b1);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, 2'h0);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  function automatic logic valid_id(input int n);
    return cfg[n].presence == `DPRR_PRESENT_VALID && cfg[n].power_id_valid_flag;
  endfunction
  function automatic logic [3:0] exp_dom(input logic [31:0] c);
    logic [3:0] m;
    m = 4'h0;
    for (int n = 0; n < `DPRR_N_ENTRIES; n++)
      if (valid_id(n) && c[n] && !c[4+n]) m[cfg[n].power_domain_number[1:0]] = 1'b1;
    return m;
  endfunction
  task automatic conclude();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end
  // Reset-wait before reading the handshake back
  task automatic rst_step(input logic [31:0] c, input logic [1:0] st, input logic rs);
    logic [31:0] d;
    logic [1:0]  r;
    wr(`DPRR_OFS_CTRL, c);
    repeat (4) @(posedge clk);
    rd(`DPRR_OFS_STATUS, d, r);
    chk(d[1:0], st);
    chk(dbg_rst, rs);
  endtask
  initial begin
    logic [31:0] c, d;
    logic [1:0]  r;
    void'($urandom(91));
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, dbg_en, sec_inv_en} = '0;
    {inv_en, root_inv_en} = 2'($urandom);
    wstrb = 4'hf;
    present = 4'hf;
    for (int i = 0; i < `DPRR_N_ENTRIES; i++)
      cfg[i] = dprr_entry_s'(7'($urandom));
    cfg[0] = '{2'h3, 1'b1, 4'h5};
    cfg[1] = '{2'h2, 1'b1, 4'h1};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`DPRR_OFS_STATUS, d, r);
    chk(d[7:4], {valid_id(3), valid_id(2), valid_id(1), valid_id(0)});
    rd(12'h100, d, r);
    chk(r, 2'h2);
    $display("test directory done");
    for (int k = 0; k < 24; k++) begin
      c = (k == 0) ? 32'h0000_030f : {22'h0, 10'($urandom)};
      dbg_en <= (k == 0) ? 1'b1 : 1'($urandom);
      present <= (k == 0) ? 4'hf : 4'($urandom);
      wr(`DPRR_OFS_CTRL, c);
      repeat (3) @(posedge clk);
      chk(lnk.domain_power_control, exp_dom(c));
      chk(dom_pwr, exp_dom(c) & present & {4{dbg_en}});
      chk(lnk.system_power_control, c[9:8]);
      chk(sys_pwr, (|c[9:8] && dbg_en) ? `DPRR_SYS_ROUTE : 4'h0);
    end
    $display("test power done");
    sec_inv_en <= 1'b1;
    rst_step(32'h0001_0000, 2'h3, 1'b1);
    rst_step(32'h0, 2'h0, 1'b0);
    sec_inv_en <= 1'b0;
    rst_step(32'h0001_0000, 2'h1, 1'b0);
    rst_step(32'h0, 2'h0, 1'b0);
    $display("test reset done");
    conclude();
  end
endmodule // tb_debug_power_reset_request
